// ===== shared/event_router_pkg.sv
package event_router_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_SELECT_HIGH = 32'h019C0000;
  localparam logic [31:0] ADDR_SELECT_LOW = 32'h019C0004;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h019C0008;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h019C000C;
  localparam logic [31:0] ADDR_EVENT_LATCH_LOW = 32'h019C0010;
  localparam logic [31:0] ADDR_EVENT_LATCH_HIGH = 32'h019C0014;
  localparam logic [31:0] ADDR_EVENT_ENABLE_LOW = 32'h019C0018;
  localparam logic [31:0] ADDR_EVENT_ENABLE_HIGH = 32'h019C001C;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ---------------------------------------------------------------
  // selector field layout and reset defaults
  // ---------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam int N_LINES = 16;
  localparam int N_MASKABLE = 12;
  localparam int FIRST_MASKABLE = 4;
  localparam int N_CHAN = 64;
  localparam int N_SRC = 32;
  // field positions for the six lines held in each selector register
  localparam int FIELD_POS [6] = '{0, 5, 10, 16, 21, 26};
  // lines 4..9 in the low register, 10..15 in the high one
  localparam logic [31:0] SELECT_LOW_RESET = 32'h250718A4;
  localparam logic [31:0] SELECT_HIGH_RESET = 32'h08202D43;
  localparam logic [31:0] SELECT_FIELD_MASK = 32'h7FFF7FFF;

  // ---------------------------------------------------------------
  // selector codes
  // ---------------------------------------------------------------
  localparam logic [4:0] SRC_HOST = 5'h00;
  localparam logic [4:0] SRC_TIMER0 = 5'h01;
  localparam logic [4:0] SRC_TIMER1 = 5'h02;
  localparam logic [4:0] SRC_SDRAM_A = 5'h03;
  localparam logic [4:0] SRC_PIN4 = 5'h04;
  localparam logic [4:0] SRC_DMA_DONE = 5'h08;
  localparam logic [4:0] SRC_PIN0 = 5'h10;
  localparam logic [4:0] SRC_TIMER2 = 5'h13;
  localparam logic [4:0] SRC_CELL = 5'h17;
  localparam logic [4:0] SRC_CONV = 5'h1E;
  localparam logic [4:0] SRC_TURBO = 5'h1F;

  // ---------------------------------------------------------------
  // source bundles
  // ---------------------------------------------------------------
  typedef struct packed {
    logic host_event;
    logic timer0_interrupt;
    logic timer1_interrupt;
    logic timer2_interrupt;
    logic first_sdram_refresh_timer_event;
    logic second_sdram_refresh_timer_event;
    logic [15:0] pin_event;
    logic [2:0] serial_transmit_event;
    logic [2:0] serial_receive_event;
    logic conv_decoder_receive_event;
    logic conv_decoder_transmit_event;
    logic turbo_decoder_receive_event;
    logic turbo_decoder_transmit_event;
    logic cell_interface_receive_event;
    logic cell_interface_transmit_event;
  } periph_events_s;

  typedef struct packed {
    logic dma_done;
    logic cell_irq;
    logic conv_irq;
    logic turbo_irq;
  } irq_extra_s;

  typedef struct packed {
    logic has_host_pci;
    logic has_cell_pci;
    logic has_decoders;
  } variant_s;

endpackage

// ===== core/event_and_interrupt_router.sv
// How it works
// - one sync event input per each of 64 dma channels, wiring fixed
// - arriving event sets its latch bit even when its enable bit is clear
// - event priority comes from the channel parameter entry, not channel number
// - ch0 host, ch1-2 timers 0/1, ch3 first sdram refresh timer
// - ch4-7 pin events 4-7, ch8-11 pins 0-3, ch48-55 pins 8-15
// - ch12-15 serial ports 0/1 tx/rx, ch17-18 port 2, ch16 unused
// - ch19 timer 2, ch20 second sdram refresh timer
// - ch28-31 conv/turbo decoder rx/tx; reserved on variants without them
// - ch32 cell rx, ch40 cell tx; reserved when cell/pci port absent
// - ch21 reserved; other unlisted channels have no peripheral source
// - every channel also accepts completion and alternate completion sync
// - sixteen core lines, line 0 reset highest, priority falls with number
// - lines 0 to 3 non-maskable with fixed sources
// - lines 4-15 maskable, default sources after reset
// - selector registers at 0x019C0000 high and 0x019C0004 low
// - 5-bit fields at 4:0,9:5,14:10,20:16,25:21,30:26 per register
// - codes map host, timers, sdram, pins, dma, timer2, cell, decoders
module event_and_interrupt_router (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // event sources (asynchronous levels)
  input wire event_router_pkg::periph_events_s periph_events,
  input wire event_router_pkg::irq_extra_s irq_extra,
  input wire logic reset_line,
  input wire logic nmi_line,
  input wire event_router_pkg::variant_s variant,
  // dma side, completion chaining from the dma logic (same clock)
  input wire logic [63:0] chain_completion,
  input wire logic [63:0] chain_alt_completion,
  input wire logic [63:0] channel_priority_sel,
  output logic [63:0] channel_sync_event,
  output logic [63:0] channel_event_priority,
  // core side
  output logic [15:0] core_interrupt,
  output logic router_irq
);
  import event_router_pkg::*;

  localparam int N_IN = $bits(periph_events_s) + $bits(irq_extra_s) + 2;

  // ---------------------------------------------------------------
  // input synchronisers and edge pulses
  // ---------------------------------------------------------------
  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] sync1;
  logic [N_IN-1:0] sync2;
  logic [N_IN-1:0] sync3;
  logic [N_IN-1:0] settled;
  logic [N_IN-1:0] pulse;
  logic [2:0] variant_q;

  assign raw_in = {periph_events, irq_extra, reset_line, nmi_line};

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // rising edge of the agreed level gives a single pulse per event
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      settled <= '0;
      pulse <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (sync2[i] == sync3[i]) begin
          settled[i] <= sync3[i];
          pulse[i] <= sync3[i] & ~settled[i];
        end else begin
          pulse[i] <= 1'b0;
        end
      end
    end
  end

  // straps held steady; caught after reset release, not by the reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      variant_q <= 3'h0;
    end else begin
      variant_q <= variant;
    end
  end

  periph_events_s ev;
  irq_extra_s ex;
  variant_s var_q;
  logic reset_pulse;
  logic nmi_pulse;

  assign {ev, ex, reset_pulse, nmi_pulse} = pulse;
  assign var_q = variant_s'(variant_q);

  // ---------------------------------------------------------------
  // fixed channel map
  // ---------------------------------------------------------------
  logic [63:0] fixed_event;

  // one fixed source per channel, unlisted channels stay zero
  always_comb begin
    fixed_event = '0;
    fixed_event[0] = ev.host_event & var_q.has_host_pci;
    fixed_event[1] = ev.timer0_interrupt;
    fixed_event[2] = ev.timer1_interrupt;
    fixed_event[3] = ev.first_sdram_refresh_timer_event;
    fixed_event[7:4] = ev.pin_event[7:4];
    fixed_event[11:8] = ev.pin_event[3:0];
    fixed_event[55:48] = ev.pin_event[15:8];
    for (int p = 0; p < 2; p++) begin
      fixed_event[12 + 2 * p] = ev.serial_transmit_event[p];
      fixed_event[13 + 2 * p] = ev.serial_receive_event[p];
    end
    fixed_event[17] = ev.serial_transmit_event[2];
    fixed_event[18] = ev.serial_receive_event[2];
    fixed_event[19] = ev.timer2_interrupt;
    fixed_event[20] = ev.second_sdram_refresh_timer_event;
    fixed_event[28] = ev.conv_decoder_receive_event & var_q.has_decoders;
    fixed_event[29] = ev.conv_decoder_transmit_event & var_q.has_decoders;
    fixed_event[30] = ev.turbo_decoder_receive_event & var_q.has_decoders;
    fixed_event[31] = ev.turbo_decoder_transmit_event & var_q.has_decoders;
    fixed_event[32] = ev.cell_interface_receive_event & var_q.has_cell_pci;
    fixed_event[40] = ev.cell_interface_transmit_event & var_q.has_cell_pci;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] interrupt_select_high;
  logic [31:0] interrupt_select_low;
  logic [63:0] channel_event_latch;
  logic [63:0] channel_event_enable;
  logic [N_MASKABLE-1:0] irq_status;
  logic [N_MASKABLE-1:0] irq_mask;
  logic access_done;
  logic [31:0] be_mask;
  logic wr_now;
  logic rd_now;

  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};
  // one wait cycle: requests are taken on the edge where waitrequest is low
  assign wr_now = write & access_done;
  assign rd_now = read & access_done;

  // waitrequest drops for one cycle after each request is seen
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      access_done <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      access_done <= (read | write) & ~access_done;
      waitrequest <= ~((read | write) & ~access_done);
    end
  end

  // selector fields, reset to the default sources
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_select_high <= SELECT_HIGH_RESET;
      interrupt_select_low <= SELECT_LOW_RESET;
    end else if (wr_now) begin
      if (address == ADDR_SELECT_HIGH) begin
        interrupt_select_high <= ((interrupt_select_high & ~be_mask)
          | (writedata & be_mask)) & SELECT_FIELD_MASK;
      end
      if (address == ADDR_SELECT_LOW) begin
        interrupt_select_low <= ((interrupt_select_low & ~be_mask)
          | (writedata & be_mask)) & SELECT_FIELD_MASK;
      end
    end
  end

  // enables and interrupt mask
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_event_enable <= '0;
      irq_mask <= '0;
    end else if (wr_now) begin
      if (address == ADDR_EVENT_ENABLE_LOW) begin
        channel_event_enable[31:0] <= (channel_event_enable[31:0] & ~be_mask)
          | (writedata & be_mask);
      end
      if (address == ADDR_EVENT_ENABLE_HIGH) begin
        channel_event_enable[63:32] <= (channel_event_enable[63:32] & ~be_mask)
          | (writedata & be_mask);
      end
      if (address == ADDR_IRQ_MASK) begin
        irq_mask <= (irq_mask & ~be_mask[11:0]) | (writedata[11:0] & be_mask[11:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // dma side: latch, sync pulses, priority pass-through
  // ---------------------------------------------------------------
  logic [63:0] latch_clear;
  logic [63:0] chan_trigger;

  assign chan_trigger = fixed_event | chain_completion | chain_alt_completion;

  // writing one clears a latch bit; a new event in that cycle wins
  always_comb begin
    latch_clear = '0;
    if (wr_now && address == ADDR_EVENT_LATCH_LOW) begin
      latch_clear[31:0] = writedata & be_mask;
    end
    if (wr_now && address == ADDR_EVENT_LATCH_HIGH) begin
      latch_clear[63:32] = writedata & be_mask;
    end
  end

  // latch ignores the enable so disabled events are not lost
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_event_latch <= '0;
    end else begin
      channel_event_latch <= (channel_event_latch & ~latch_clear) | chan_trigger;
    end
  end

  // priority is whatever the channel's parameter entry says
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_sync_event <= '0;
      channel_event_priority <= '0;
    end else begin
      channel_sync_event <= chan_trigger;
      channel_event_priority <= channel_priority_sel;
    end
  end

  // ---------------------------------------------------------------
  // interrupt selectors
  // ---------------------------------------------------------------
  logic [N_SRC-1:0] src_vec;
  logic [N_MASKABLE-1:0] line_pulse;

  // source table by code; reserved and undriven codes stay zero
  always_comb begin
    src_vec = '0;
    src_vec[SRC_HOST] = ev.host_event;
    src_vec[SRC_TIMER0] = ev.timer0_interrupt;
    src_vec[SRC_TIMER1] = ev.timer1_interrupt;
    src_vec[SRC_SDRAM_A] = ev.first_sdram_refresh_timer_event;
    for (int k = 0; k < 4; k++) begin
      src_vec[SRC_PIN4 + k] = ev.pin_event[4 + k];
    end
    src_vec[SRC_DMA_DONE] = ex.dma_done;
    src_vec[SRC_PIN0] = ev.pin_event[0];
    src_vec[SRC_TIMER2] = ev.timer2_interrupt;
    src_vec[SRC_CELL] = ex.cell_irq;
    src_vec[SRC_CONV] = ex.conv_irq;
    src_vec[SRC_TURBO] = ex.turbo_irq;
  end

  genvar g;
  generate
    for (g = 0; g < N_MASKABLE; g++) begin : g_line
      localparam int POS = FIELD_POS[g % 6];
      logic [4:0] code;
      // lines 4..9 read the low register, 10..15 the high one
      assign code = (g < 6) ? interrupt_select_low[POS +: SEL_W]
                            : interrupt_select_high[POS +: SEL_W];
      assign line_pulse[g] = src_vec[code];
    end
  endgenerate

  // core lines; lines 0..3 fixed, the core resolves priority by number
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_interrupt <= '0;
    end else begin
      core_interrupt[0] <= reset_pulse;
      core_interrupt[1] <= nmi_pulse;
      core_interrupt[3:2] <= 2'h0;
      core_interrupt[15:4] <= line_pulse;
    end
  end

  // ---------------------------------------------------------------
  // router status interrupt, cleared by reading it
  // ---------------------------------------------------------------
  logic status_read;

  assign status_read = rd_now && address == ADDR_IRQ_STATUS;

  // sticky; a read clears only what it reported, later pulses survive
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
    end else if (status_read) begin
      irq_status <= (irq_status & ~readdata[N_MASKABLE-1:0]) | line_pulse;
    end else begin
      irq_status <= irq_status | line_pulse;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      router_irq <= 1'b0;
    end else begin
      router_irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= '0;
    end else if (read & ~access_done) begin
      case (address)
        ADDR_SELECT_HIGH: readdata <= interrupt_select_high;
        ADDR_SELECT_LOW: readdata <= interrupt_select_low;
        ADDR_IRQ_STATUS: readdata <= {20'h00000, irq_status};
        ADDR_IRQ_MASK: readdata <= {20'h00000, irq_mask};
        ADDR_EVENT_LATCH_LOW: readdata <= channel_event_latch[31:0];
        ADDR_EVENT_LATCH_HIGH: readdata <= channel_event_latch[63:32];
        ADDR_EVENT_ENABLE_LOW: readdata <= channel_event_enable[31:0];
        ADDR_EVENT_ENABLE_HIGH: readdata <= channel_event_enable[63:32];
        default: readdata <= UNMAPPED_READ;
      endcase
    end
  end

endmodule

// ===== tb/router_assertions.sv
module router_assertions
  import event_router_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // dma side
  input wire logic [63:0] chain_completion,
  input wire logic [63:0] chain_alt_completion,
  input wire logic [63:0] channel_priority_sel,
  input wire logic [63:0] channel_sync_event,
  input wire logic [63:0] channel_event_priority,
  // core side and straps
  input wire logic [15:0] core_interrupt,
  input wire event_router_pkg::variant_s variant
);
  timeunit 1ns;
  timeprecision 1ns;
  // channels that carry no peripheral event at all
  localparam logic [63:0] NO_SOURCE = 64'hFF00_FEFE_0FE1_0000;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without a request");
  lines_fixed_a: assert property (core_interrupt[3:2] == 2'b00)
    else $error("reserved core line asserted");
  line_pulse_a: assert property (core_interrupt[4] |=> !core_interrupt[4])
    else $error("line 4 pulse wider than one cycle");
  no_source_a: assert property ((channel_sync_event & NO_SOURCE) != 64'h0
    |-> ($past(chain_completion | chain_alt_completion) & NO_SOURCE) != 64'h0)
    else $error("sourceless channel fired");
  chain_sync_a: assert property ((chain_completion | chain_alt_completion) != 64'h0
    |=> (channel_sync_event & $past(chain_completion | chain_alt_completion))
    == $past(chain_completion | chain_alt_completion))
    else $error("completion did not trigger its channel");
  prio_follow_a: assert property (##1 channel_event_priority == $past(channel_priority_sel))
    else $error("priority not taken from channel entry");
  decoder_off_a: assert property ((!variant.has_decoders && !$past(variant.has_decoders, 2)
    && $past(chain_completion[31:28] | chain_alt_completion[31:28]) == 4'h0)
    |-> channel_sync_event[31:28] == 4'h0)
    else $error("decoder channel fired on variant without decoders");
endmodule

bind event_and_interrupt_router router_assertions chk_u (.ref_clk, .rstn, .read, .write,
  .waitrequest, .chain_completion, .chain_alt_completion, .channel_priority_sel,
  .channel_sync_event, .channel_event_priority, .core_interrupt, .variant);

// ===== tb/dma_core_partner.sv
module dma_core_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // router outputs seen by dma and core
  input wire logic [63:0] channel_sync_event,
  input wire logic [15:0] core_interrupt,
  // dma side drive
  output logic [63:0] chain_completion,
  output logic [63:0] chain_alt_completion,
  output logic [63:0] channel_priority_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  int chan_cnt [64];
  int line_cnt [16];

  initial begin
    chain_completion = 64'h0;
    chain_alt_completion = 64'h0;
    channel_priority_sel = 64'h0;
  end
  // count high cycles, so a stretched pulse reads as a second event
  always @(posedge ref_clk) begin
    for (int i = 0; i < 64; i++) begin
      if (rstn && channel_sync_event[i] === 1'b1) chan_cnt[i]++;
    end
    for (int i = 0; i < 16; i++) begin
      if (rstn && core_interrupt[i] === 1'b1) line_cnt[i]++;
    end
  end
  // one-cycle completion pulse, as the transfer logic issues it
  task send_chain(input int ch, input bit alt);
    @(posedge ref_clk);
    if (alt) chain_alt_completion <= 64'h1 << ch;
    else chain_completion <= 64'h1 << ch;
    @(posedge ref_clk);
    chain_completion <= 64'h0;
    chain_alt_completion <= 64'h0;
  endtask
  // priority fields of the parameter entries, one per channel
  task set_prio(input logic [63:0] v);
    @(posedge ref_clk);
    channel_priority_sel <= v;
  endtask
endmodule

// ===== tb/event_and_interrupt_router_test.sv
module event_and_interrupt_router_test;
  timeunit 1ns;
  timeprecision 1ns;
  import event_router_pkg::*;
  // ----------
  // stimulus and model state
  // ----------
  localparam int CHAN_TAB [40] = '{40, 32, 31, 30, 29, 28, 13, 15, 18, 12, 14, 17, 8, 9, 10,
    11, 4, 5, 6, 7, 48, 49, 50, 51, 52, 53, 54, 55, 20, 3, 19, 2, 1, 0, -1, -1, -1, -1, -1, -1};
  localparam int CODE_TAB [40] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 16, -1, -1,
    -1, 4, 5, 6, 7, -1, -1, -1, -1, -1, -1, -1, -1, -1, 3, 19, 2, 1, 0, 31, 30, 23, 8, -1, -1};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] address = 32'h0;
  logic [31:0] writedata = 32'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [39:0] src_lvl = 40'h0;
  variant_s variant = 3'h7;
  logic [31:0] readdata;
  logic waitrequest;
  logic [63:0] chain_completion, chain_alt_completion, channel_priority_sel;
  logic [63:0] channel_sync_event, channel_event_priority;
  logic [15:0] core_interrupt;
  logic router_irq;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rng = 32'h89FB;
  int exp_chan [64];
  int exp_line [16];
  int sel [16];
  logic [11:0] exp_stat = 12'h0;
  logic [63:0] exp_latch = 64'h0;

  always #25 ref_clk = ~ref_clk;

  event_and_interrupt_router dut_u (.ref_clk, .rstn, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .periph_events(src_lvl[33:0]),
    .irq_extra(src_lvl[37:34]), .reset_line(src_lvl[38]), .nmi_line(src_lvl[39]), .variant,
    .chain_completion, .chain_alt_completion, .channel_priority_sel, .channel_sync_event,
    .channel_event_priority, .core_interrupt, .router_irq);
  dma_core_partner partner_u (.ref_clk, .rstn, .channel_sync_event, .core_interrupt,
    .chain_completion, .chain_alt_completion, .channel_priority_sel);
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [31:0] mk(logic [4:0] a, b, c, d, e, f);
    return {1'b0, f, e, d, 1'b0, c, b, a};
  endfunction
  function automatic void setsel(int base, logic [31:0] v);
    for (int j = 0; j < 6; j++) sel[base + j] = int'((v >> FIELD_POS[j]) & 32'h1F);
  endfunction
  task check(input logic [63:0] seen, input logic [63:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one avalon transfer; request held until waitrequest is sampled low
  task bus(input bit we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= !we;
    write <= we;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      print_verdict();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (we && a == ADDR_SELECT_LOW) setsel(4, d);
    if (we && a == ADDR_SELECT_HIGH) setsel(10, d);
  endtask
  // pulse one source, update the model, compare every channel and line
  task fire(input int s);
    int c;
    @(posedge ref_clk);
    src_lvl[s] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    src_lvl[s] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    c = CHAN_TAB[s];
    if (s <= 1 && !variant.has_cell_pci) c = -1;
    if (s >= 2 && s <= 5 && !variant.has_decoders) c = -1;
    if (s == 33 && !variant.has_host_pci) c = -1;
    if (c >= 0) exp_chan[c]++;
    if (c >= 0) exp_latch[c] = 1'b1;
    if (s >= 38) exp_line[s - 38]++;
    for (int l = 4; l < 16; l++) begin
      if (CODE_TAB[s] >= 0 && sel[l] == CODE_TAB[s]) begin
        exp_line[l]++;
        exp_stat[l - 4] = 1'b1;
      end
    end
    for (int i = 0; i < 64; i++) check(partner_u.chan_cnt[i], exp_chan[i]);
    for (int i = 0; i < 16; i++) check(partner_u.line_cnt[i], exp_line[i]);
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    logic [31:0] q;
    logic [31:0] lo [3];
    logic [31:0] hi [3];
    logic [63:0] pv;
    int w;
    lo[0] = mk(5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09);
    hi[0] = mk(5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02);
    lo[1] = mk(5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05);
    hi[1] = mk(5'h06, 5'h07, 5'h08, 5'h10, 5'h13, 5'h17);
    lo[2] = mk(5'h1E, 5'h1F, 5'h15, 5'h09, 5'h0C, 5'h14);
    hi[2] = xs();
    setsel(4, lo[0]);
    setsel(10, hi[0]);
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check({core_interrupt, router_irq}, 17'h0);
    bus(1'b1, 32'h019C0040, 32'hFFFFFFFF, q);
    bus(1'b0, 32'h019C0040, 32'h0, q);
    check(q, UNMAPPED_READ);
    for (int p = 0; p < 3; p++) begin
      if (p > 0) bus(1'b1, ADDR_SELECT_LOW, lo[p], q);
      if (p > 0) bus(1'b1, ADDR_SELECT_HIGH, hi[p], q);
      bus(1'b0, ADDR_SELECT_LOW, 32'h0, q);
      check(q, lo[p]);
      bus(1'b0, ADDR_SELECT_HIGH, 32'h0, q);
      check(q, hi[p] & 32'h7FFF7FFF);
      bus(1'b1, ADDR_EVENT_ENABLE_LOW, (p == 1) ? 32'hFFFFFFFF : 32'h0, q);
      bus(1'b0, ADDR_EVENT_ENABLE_LOW, 32'h0, q);
      check(q, (p == 1) ? 32'hFFFFFFFF : 32'h0);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
      exp_stat = 12'h0;
      for (int s = 0; s < 40; s++) fire(s);
      bus(1'b1, ADDR_IRQ_MASK, 32'hFFF, q);
      repeat (2) @(posedge ref_clk);
      check(router_irq, exp_stat != 12'h0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h0, q);
      repeat (2) @(posedge ref_clk);
      check(router_irq, 1'b0);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
      check(q, {20'h0, exp_stat});
      bus(1'b1, ADDR_IRQ_MASK, 32'hFFF, q);
      repeat (2) @(posedge ref_clk);
      check(router_irq, 1'b0);
      bus(1'b0, ADDR_EVENT_LATCH_LOW, 32'h0, q);
      check(q, exp_latch[31:0]);
      bus(1'b0, ADDR_EVENT_LATCH_HIGH, 32'h0, q);
      check(q, exp_latch[63:32]);
      bus(1'b1, ADDR_EVENT_LATCH_LOW, 32'hFFFFFFFF, q);
      bus(1'b1, ADDR_EVENT_LATCH_HIGH, 32'hFFFFFFFF, q);
      exp_latch = 64'h0;
      $display("selector pass %0d done", p);
    end
    // completion chaining onto random channels, then random priorities
    for (int i = 0; i < 6; i++) begin
      w = int'(xs() % 64);
      partner_u.send_chain(w, i[0]);
      repeat (3) @(posedge ref_clk);
      exp_chan[w]++;
      check(partner_u.chan_cnt[w], exp_chan[w]);
      pv = {xs(), xs()};
      partner_u.set_prio(pv);
      repeat (2) @(posedge ref_clk);
      check(channel_event_priority, pv);
    end
    $display("chain and priority done");
    // only the second byte lane may touch the mask
    byteenable <= 4'h2;
    bus(1'b1, ADDR_IRQ_MASK, 32'h0, q);
    byteenable <= 4'hF;
    bus(1'b0, ADDR_IRQ_MASK, 32'h0, q);
    check(q, 32'h0FF);
    $display("byte enable done");
    // straps changed only while no event is in flight
    variant <= 3'h0;
    repeat (4) @(posedge ref_clk);
    for (int s = 0; s < 6; s++) fire(s);
    fire(33);
    $display("variant straps done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule
